// ===== logic/nmi_entry_pkg.sv
// Constants for the reset and NMI entry block
package nmi_entry_pkg;
  localparam int          VEC_W          = 31;
  localparam int          GPR_COUNT      = 31;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [31:0] CAUSE_PIN      = 32'h0000_0000;
  localparam logic [31:0] CAUSE_ST_ERR   = 32'hf000_0000;
  localparam logic [31:0] CAUSE_LD_ERR   = 32'hf000_0001;
  localparam logic [31:0] CAUSE_RESET    = 32'h0000_0000;
  localparam logic [31:0] ERR_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] GPR_RESET      = 32'h0000_0000;
endpackage : nmi_entry_pkg

// ===== logic/pin_sync.sv
// Two-stage synchroniser for an asynchronous pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int STAGES = 2
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      pin_sync_out
);
  logic [STAGES-1:0] sync_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], pin_in};
    end
  end

  assign pin_sync_out = sync_q[STAGES-1];
endmodule : pin_sync
`default_nettype wire

// ===== logic/reset_and_nmi_entry.sv
// Reset and non-maskable interrupt entry logic of the core
`timescale 1ns/100ps
`default_nettype none
module reset_and_nmi_entry (
  input  wire logic                               ref_clk,
  input  wire logic                               rstn,
  input  wire logic [nmi_entry_pkg::VEC_W:1]      rst_vec,
  input  wire logic [nmi_entry_pkg::VEC_W:1]      nmi_vec,
  input  wire logic                               nmi_pin,
  input  wire logic                               st_err,
  input  wire logic                               ld_err,
  input  wire logic [31:0]                        err_addr,
  input  wire logic                               unlock_wr,
  input  wire logic                               vectored_mode,
  input  wire logic [4:0]                         gpr_idx,
  input  wire logic                               gpr_wr,
  input  wire logic [31:0]                        gpr_wdata,
  output logic                                    fetch_redirect,
  output logic [31:0]                             fetch_addr,
  output logic [31:0]                             cause,
  output logic                                    cause_wr,
  output logic [31:0]                             err_addr_cap,
  output logic                                    err_locked,
  output logic [31:0]                             gpr_rdata
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01
  } entry_state_e;

  entry_state_e state_q;
  logic         nmi_sync;
  logic         nmi_prev_q;
  logic         pin_event;
  logic         bus_event;
  logic         lock_q;
  logic [31:0]  cause_d;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // two-flop synchroniser
  pin_sync #(
    .STAGES (nmi_entry_pkg::SYNC_STAGES)
  ) u_nmi_sync (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .pin_in       (nmi_pin),
    .pin_sync_out (nmi_sync)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_sync;
    end
  end

  assign pin_event = nmi_sync & ~nmi_prev_q;

  assign bus_event = (st_err | ld_err) & ~lock_q;

  // ----------------------------------------------------------------
  // Error address capture and lock
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_q       <= 1'b0;
      err_addr_cap <= nmi_entry_pkg::ERR_ADDR_RESET;
    end else if (bus_event) begin
      // capture and lock; while locked, unlock wins and a new error is dropped
      lock_q       <= 1'b1;
      err_addr_cap <= err_addr;
    end else if (unlock_wr) begin
      lock_q <= 1'b0;
    end
  end

  assign err_locked = lock_q;

  // ----------------------------------------------------------------
  // Cause selection
  // ----------------------------------------------------------------
  always_comb begin
    // cause codes; store error before load error
    if (bus_event && st_err) begin
      cause_d = nmi_entry_pkg::CAUSE_ST_ERR;
    end else if (bus_event) begin
      cause_d = nmi_entry_pkg::CAUSE_LD_ERR;
    end else begin
      cause_d = nmi_entry_pkg::CAUSE_PIN;
    end
  end

  // ----------------------------------------------------------------
  // Fetch redirect sequencing
  // ----------------------------------------------------------------
  // async assert, release sampled on clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= ST_RESET;
      fetch_redirect <= 1'b0;
      fetch_addr     <= 32'h0000_0000;
      cause          <= nmi_entry_pkg::CAUSE_RESET;
      cause_wr       <= 1'b0;
    end else begin
      fetch_redirect <= 1'b0;
      cause_wr       <= 1'b0;
      case (state_q)
        ST_RESET: begin
          fetch_redirect <= 1'b1;
          fetch_addr     <= {rst_vec, 1'b0};
          state_q        <= ST_RUN;
        end
        ST_RUN: begin
          if (pin_event || bus_event) begin
            fetch_redirect <= 1'b1;
            fetch_addr     <= {nmi_vec, 1'b0};
            cause          <= cause_d;
            cause_wr       <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // General registers x1..x31
  // ----------------------------------------------------------------
  logic [31:0] gpr_q [1:nmi_entry_pkg::GPR_COUNT];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 1; i <= nmi_entry_pkg::GPR_COUNT; i++) begin
        gpr_q[i] <= nmi_entry_pkg::GPR_RESET;
      end
    end else if (gpr_wr && gpr_idx != 5'h00) begin
      gpr_q[gpr_idx] <= gpr_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gpr_rdata <= nmi_entry_pkg::GPR_RESET;
    end else if (gpr_idx == 5'h00) begin
      gpr_rdata <= nmi_entry_pkg::GPR_RESET;
    end else begin
      gpr_rdata <= gpr_q[gpr_idx];
    end
  end

  logic unused_mode;
  assign unused_mode = vectored_mode;

endmodule : reset_and_nmi_entry
`default_nettype wire

// ===== tb/nmi_entry_asserts.sv
// Port checker for the reset and NMI entry block
`timescale 1ns/100ps
`default_nettype none
module nmi_entry_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [31:1] rst_vec,
  input wire logic [31:1] nmi_vec,
  input wire logic        nmi_pin,
  input wire logic        st_err,
  input wire logic        ld_err,
  input wire logic [31:0] err_addr,
  input wire logic        unlock_wr,
  input wire logic        fetch_redirect,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] cause,
  input wire logic        cause_wr,
  input wire logic [31:0] err_addr_cap,
  input wire logic        err_locked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [31:0] nv = {nmi_vec, 1'b0};
  wire logic        ev = st_err || ld_err;
  rst_fetch_a: assert property ($rose(rstn)
    |-> ##[1:2] fetch_redirect && fetch_addr == {rst_vec, 1'b0}) else $error("reset fetch");
  st_entry_a: assert property (st_err && !err_locked && $past(rstn)
    |=> cause_wr && cause == nmi_entry_pkg::CAUSE_ST_ERR) else $error("store entry");
  ld_entry_a: assert property (ld_err && !st_err && !err_locked && $past(rstn)
    |=> cause_wr && cause == nmi_entry_pkg::CAUSE_LD_ERR) else $error("load entry");
  err_cap_a: assert property (ev && !err_locked
    |=> err_locked && err_addr_cap == $past(err_addr)) else $error("capture");
  err_gate_a: assert property (ev && err_locked && !unlock_wr
    |=> err_locked && $stable(err_addr_cap)) else $error("gate");
  lock_release_a: assert property (unlock_wr && err_locked |=> !err_locked)
    else $error("unlock");
  nmi_target_a: assert property (cause_wr |-> fetch_redirect && fetch_addr == nv)
    else $error("nmi target");
  pin_entry_a: assert property ($rose(nmi_pin) |-> ##[1:5] cause_wr)
    else $error("pin entry");
  cover property (cause_wr && cause == nmi_entry_pkg::CAUSE_LD_ERR);
  cover property (unlock_wr && err_locked);
  cover property ($rose(nmi_pin) && err_locked);
endmodule : nmi_entry_asserts
bind reset_and_nmi_entry nmi_entry_asserts chk (.*);
`default_nettype wire

// ===== tb/soc_model.sv
// System side model: vectors and NMI pin pulses
`timescale 1ns/100ps
`default_nettype none
module soc_model #(
  parameter logic [31:0] RST_A = 32'h0004_0100,
  parameter logic [31:0] NMI_A = 32'h0004_0800
) (
  input  wire logic        ref_clk,
  input  wire logic        fire,
  output logic      [31:1] rst_vec,
  output logic      [31:1] nmi_vec,
  output logic             nmi_pin
);
  logic [2:0] cnt_q = 3'h0;
  assign rst_vec = RST_A[31:1];
  assign nmi_vec = NMI_A[31:1];
  always @(posedge ref_clk) cnt_q <= fire ? 3'h5 : cnt_q - {2'h0, cnt_q != 3'h0};
  assign nmi_pin = cnt_q > 3'h2;
endmodule : soc_model
`default_nettype wire

// ===== tb/reset_and_nmi_entry_tb_top.sv
// Self-checking bench for the reset and NMI entry block
`timescale 1ns/100ps
`default_nettype none
module reset_and_nmi_entry_tb_top;
  localparam logic [31:0] RST_A = 32'h0004_0100;
  localparam logic [31:0] NMI_A = 32'h0004_0800;
  logic ref_clk = 1'b0, rstn = 1'b0, fire = 1'b0, st_err = 1'b0, ld_err = 1'b0;
  logic unlock_wr = 1'b0, vectored_mode = 1'b0, gpr_wr = 1'b0, nmi_pin;
  logic [4:0] gpr_idx = 5'h1f;
  logic [31:0] err_addr = 32'h0, gpr_wdata = 32'h0, fetch_addr, cause, err_addr_cap, gpr_rdata;
  logic [31:1] rst_vec, nmi_vec;
  logic fetch_redirect, cause_wr, err_locked;
  int error_cnt = 0, checked = 0, cyc = 0;
  soc_model #(.RST_A(RST_A), .NMI_A(NMI_A)) SOC (.*);
  reset_and_nmi_entry DUT (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic count(output int n);
    n = 0;
    repeat (8) begin
      #1;
      if (cause_wr === 1'b1) n++;
      @(posedge ref_clk);
    end
  endtask : count
  task automatic drive(input logic st, ld, input logic [31:0] a, input logic unl);
    int n;
    @(posedge ref_clk);
    {st_err, ld_err, err_addr} <= {st, ld, a};
    @(posedge ref_clk);
    {st_err, ld_err, unlock_wr} <= {2'h0, unl};
    @(posedge ref_clk);
    unlock_wr <= 1'b0;
  endtask : drive
  task automatic t_reset();
    int n = 0;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      if (fetch_redirect === 1'b1) n++;
    end
    chk(n == 1 && fetch_addr === RST_A, "reset fetch");
    chk(gpr_rdata === 32'h0 && err_locked === 1'b0, "reset state");
    $display("reset test done");
  endtask : t_reset
  task automatic t_err(input logic st, ld, input logic [31:0] a, ex);
    int n;
    drive(st, ld, a, 1'b0);
    chk(cause === ex && fetch_addr === NMI_A && err_addr_cap === a, "error entry");
    drive(1'b0, 1'b0, a, 1'b1);
    #1;
    chk(err_locked === 1'b0, "unlock");
    $display("error test done");
  endtask : t_err
  task automatic t_pin();
    int n;
    @(posedge ref_clk);
    vectored_mode <= 1'b1;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    count(n);
    chk(n == 1 && cause === 32'h0 && fetch_addr === NMI_A, "pin entry");
    $display("pin test done");
  endtask : t_pin
  task automatic t_locked();
    int n;
    drive(1'b0, 1'b1, 32'h0000_0a0c, 1'b0);
    drive(1'b1, 1'b0, 32'h0000_0b0c, 1'b0);
    count(n);
    chk(n == 0 && err_addr_cap === 32'h0000_0a0c, "gated error");
    t_pin();
    $display("locked test done");
  endtask : t_locked
  task automatic t_gpr();
    @(posedge ref_clk);
    {gpr_wr, gpr_idx, gpr_wdata} <= {1'b1, 5'h05, 32'h5a5a_0005};
    @(posedge ref_clk);
    gpr_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(gpr_rdata === 32'h5a5a_0005, "register write");
    $display("register test done");
  endtask : t_gpr
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    t_reset();
    t_err(1'b1, 1'b0, 32'h0000_1004, nmi_entry_pkg::CAUSE_ST_ERR);
    t_err(1'b0, 1'b1, 32'h0000_2008, nmi_entry_pkg::CAUSE_LD_ERR);
    t_err(1'b1, 1'b1, 32'h0000_300c, nmi_entry_pkg::CAUSE_ST_ERR);
    t_pin();
    t_locked();
    t_gpr();
    t_reset();
    report_and_stop();
  end
endmodule : reset_and_nmi_entry_tb_top
`default_nettype wire
